// *** rtl/scc_defs.svh ***
// Offsets, field positions, reset values and timing counts of the SPI control block
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// ============================================================
// Register byte offsets
`define SCC_ADDR_W            16
`define SCC_OFS_MASTER_CTRL   16'hF800
`define SCC_OFS_CTRL_ZERO     16'hF804
`define SCC_OFS_GAP           16'hF80C
`define SCC_OFS_IRQ_STATUS    16'hF814
`define SCC_OFS_IRQ_MASK      16'hF820

// ============================================================
// Control-zero field positions
`define SCC_TX_THR_HI         15
`define SCC_TX_THR_LO         14
`define SCC_RX_THR_HI         13
`define SCC_RX_THR_LO         12
`define SCC_IDLE_EN_BIT       11
`define SCC_OVR_EN_BIT        10
`define SCC_RXF_EN_BIT        9
`define SCC_TXF_EN_BIT        8
`define SCC_PRESCALE_BIT      4
`define SCC_ORDER_BIT         2
`define SCC_PHASE_BIT         1
`define SCC_POLARITY_BIT      0
`define SCC_CTRL_ZERO_MASK    32'h0000FF17
`define SCC_CTRL_ZERO_PROT    32'h00000017
`define SCC_CTRL_ZERO_RESET   32'h00000000

// ============================================================
// Master control, gap and interrupt layouts
`define SCC_MODE_HI           7
`define SCC_MODE_LO           6
`define SCC_MODE_RESET        2'h0
`define SCC_GAP_W             10
`define SCC_GAP_RESET         10'h000
`define SCC_IRQ_W             4
`define SCC_IRQ_IDLE          0
`define SCC_IRQ_OVR           1
`define SCC_IRQ_RXF           2
`define SCC_IRQ_TXF           3
`define SCC_IRQ_RESET         4'h0

// ============================================================
// Timing
`define SCC_PRESCALE_DIV      32
`define SCC_PRESCALE_LAST     5'h1F
`define SCC_FIFO_CNT_W        3

`endif

// *** rtl/scc_pkg.sv ***
// Types shared by the SPI control block
package scc_pkg;

    // Operation mode field encodings
    typedef enum logic [1:0] {
        SCC_MODE_DONT_CARE = 2'b00,
        SCC_MODE_CONFIG    = 2'b01,
        SCC_MODE_ACTIVE    = 2'b10,
        SCC_MODE_RESERVED  = 2'b11
    } scc_mode_type;

endpackage

// *** rtl/scc_ctrl.sv ***
// SPI master control and interrupt configuration block with a Wishbone slave
// Notes on behaviour
// - TX fill raised when free TX entries reach threshold code plus one.
// - RX fill raised when held RX entries reach threshold code plus one.
// - Bit 11 lets the idle condition reach the interrupt.
// - Bit 10 lets the overrun flag reach the interrupt.
// - Bit 9 lets RX fill reach the interrupt, else status only.
// - Bit 8 lets TX fill reach the interrupt, else status only.
// - Bit 4 slows the gap counter to one step per 32 clocks.
// - Bit 2 picks MSB first when set, LSB first when clear.
// - Bit 1 picks sample-then-shift or shift-then-sample clock phase.
// - Bit 0 sets the serial clock idle level high when set.
// - Bits 4, 2, 1, 0 are written only in configuration mode.
// - Control register resets to all zeros.
// - Mode field 01 is configuration, 10 active, 11 reserved.
// - Gap lasts delay value clocks, times 32 with prescaler; zero none.
// - Interrupt output is OR of the enabled source groups.
`include "scc_defs.svh"
`timescale 1ns/1ps

module scc_ctrl
    import scc_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    // Wishbone classic slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [`SCC_ADDR_W-1:0]        wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // Shift engine and FIFO side, same clock
    input  wire logic [`SCC_FIFO_CNT_W-1:0]    tx_free_count_i,
    input  wire logic [`SCC_FIFO_CNT_W-1:0]    rx_held_count_i,
    input  wire logic                          idle_flag_i,
    input  wire logic                          overrun_flag_i,
    input  wire logic                          frame_end_i,
    // Configuration outputs
    output logic [1:0]                         operation_mode_o,
    output logic                               config_mode_o,
    output logic                               active_mode_o,
    output logic                               bit_order_select_o,
    output logic                               clock_phase_o,
    output logic                               clock_polarity_o,
    output logic                               sample_on_rise_o,
    output logic                               gap_active_o,
    output logic                               tx_fill_flag_o,
    output logic                               rx_fill_flag_o,
    output logic                               irq_o
);

    // ============================================================
    // Registers
    logic [31:0]               ctrl_zero_ff;
    logic [31:0]               nxt_ctrl_zero;
    logic [1:0]                mode_ff;
    logic [1:0]                nxt_mode;
    logic [`SCC_GAP_W-1:0]     gap_val_ff;
    logic [`SCC_GAP_W-1:0]     nxt_gap_val;
    logic [`SCC_IRQ_W-1:0]     irq_status_ff;
    logic [`SCC_IRQ_W-1:0]     nxt_irq_status;
    logic [`SCC_IRQ_W-1:0]     irq_mask_ff;
    logic [`SCC_IRQ_W-1:0]     nxt_irq_mask;
    logic                      ack_ff;
    logic [31:0]               rdata_ff;
    logic                      sample_rise_ff;
    logic                      tx_fill_ff;
    logic                      rx_fill_ff;
    logic                      irq_ff;
    logic [`SCC_GAP_W-1:0]     gap_left_ff;
    logic [`SCC_GAP_W-1:0]     nxt_gap_left;
    logic [4:0]                pre_cnt_ff;
    logic [4:0]                nxt_pre_cnt;
    logic                      gap_active_ff;
    logic                      nxt_gap_active;
    logic                      config_ff;
    logic                      nxt_config;
    logic                      active_ff;
    logic                      nxt_active;

    // ============================================================
    // Bus decode
    // Request is served at the edge where ack is already high, so a write
    // lands exactly once, on the edge the master samples ack
    wire        bus_req     = wb_cyc_i & wb_stb_i;
    wire        bus_commit  = bus_req & ack_ff;
    wire        bus_wr      = bus_commit & wb_we_i;
    wire [13:0] word_adr    = wb_adr_i[`SCC_ADDR_W-1:2];
    // Unmapped words still ack, so a stray access never hangs the bus
    wire        hit_master  = (word_adr == 14'(`SCC_OFS_MASTER_CTRL >> 2));
    wire        hit_ctrl0   = (word_adr == 14'(`SCC_OFS_CTRL_ZERO >> 2));
    wire        hit_gap     = (word_adr == 14'(`SCC_OFS_GAP >> 2));
    wire        hit_status  = (word_adr == 14'(`SCC_OFS_IRQ_STATUS >> 2));
    wire        hit_mask    = (word_adr == 14'(`SCC_OFS_IRQ_MASK >> 2));
    wire [31:0] lane_mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wdata_lane  = wb_dat_i & lane_mask;

    // ============================================================
    // Mode decode
    wire        in_config   = (mode_ff == SCC_MODE_CONFIG);
    // Reserved code 11 is stored but acts as neither mode

    // ============================================================
    // Control-zero write path
    // Protected lanes drop out of the write mask unless configuring
    wire [31:0] ctrl0_allow = in_config ? `SCC_CTRL_ZERO_MASK
                            : (`SCC_CTRL_ZERO_MASK & ~`SCC_CTRL_ZERO_PROT);
    wire [31:0] ctrl0_wmask = lane_mask & ctrl0_allow;
    assign nxt_ctrl_zero = (bus_wr && hit_ctrl0)
                         ? ((ctrl_zero_ff & ~ctrl0_wmask) | (wb_dat_i & ctrl0_wmask))
                         : ctrl_zero_ff;

    // Mode, gap value and mask writes
    assign nxt_mode    = (bus_wr && hit_master && wb_sel_i[0])
                       ? wb_dat_i[`SCC_MODE_HI:`SCC_MODE_LO] : mode_ff;
    assign nxt_gap_val = (bus_wr && hit_gap)
                       ? ((gap_val_ff & ~lane_mask[`SCC_GAP_W-1:0])
                          | wdata_lane[`SCC_GAP_W-1:0])
                       : gap_val_ff;
    assign nxt_irq_mask = (bus_wr && hit_mask && wb_sel_i[0])
                        ? wb_dat_i[`SCC_IRQ_W-1:0] : irq_mask_ff;

    // Flags decoded from the next mode, so they move with the mode register
    assign nxt_config   = (nxt_mode == SCC_MODE_CONFIG);
    assign nxt_active   = (nxt_mode == SCC_MODE_ACTIVE);

    // ============================================================
    // Field views
    wire [1:0]  tx_thr      = ctrl_zero_ff[`SCC_TX_THR_HI:`SCC_TX_THR_LO];
    wire [1:0]  rx_thr      = ctrl_zero_ff[`SCC_RX_THR_HI:`SCC_RX_THR_LO];
    wire        prescale_on = ctrl_zero_ff[`SCC_PRESCALE_BIT];
    // Enable bits gathered in status bit order
    wire [`SCC_IRQ_W-1:0] src_enable = {ctrl_zero_ff[`SCC_TXF_EN_BIT],
                                        ctrl_zero_ff[`SCC_RXF_EN_BIT],
                                        ctrl_zero_ff[`SCC_OVR_EN_BIT],
                                        ctrl_zero_ff[`SCC_IDLE_EN_BIT]};

    // ============================================================
    // Fill conditions
    // Code n means n+1 entries, so code 11 asks for the full depth of four
    // Counts share this clock, so they need no synchroniser
    wire [`SCC_FIFO_CNT_W-1:0] tx_need = {1'b0, tx_thr} + 3'h1;
    wire [`SCC_FIFO_CNT_W-1:0] rx_need = {1'b0, rx_thr} + 3'h1;
    wire        tx_fill_now = (tx_free_count_i >= tx_need);
    wire        rx_fill_now = (rx_held_count_i >= rx_need);

    // ============================================================
    // Sticky interrupt status
    // A source that is set in the same cycle as a write-one clear stays set
    // Clearing a still-true condition is useless: it sets again at once
    wire [`SCC_IRQ_W-1:0] irq_event = {tx_fill_now, rx_fill_now,
                                       overrun_flag_i, idle_flag_i};
    wire [`SCC_IRQ_W-1:0] irq_clear = (bus_wr && hit_status && wb_sel_i[0])
                                    ? wb_dat_i[`SCC_IRQ_W-1:0] : `SCC_IRQ_RESET;
    assign nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_event;

    // Enabled sources grouped as error-or-idle, receive fill, transmit fill
    wire [`SCC_IRQ_W-1:0] irq_live = nxt_irq_status & irq_mask_ff & src_enable;
    wire        grp_err_idle = irq_live[`SCC_IRQ_IDLE] | irq_live[`SCC_IRQ_OVR];
    wire        grp_rx       = irq_live[`SCC_IRQ_RXF];
    wire        grp_tx       = irq_live[`SCC_IRQ_TXF];
    wire        nxt_irq      = grp_err_idle | grp_rx | grp_tx;

    // ============================================================
    // Interframe gap timer
    // Prescaler divides by 32 so the gap stays countable with 10 bits
    // A frame end inside a gap restarts it from the full value
    wire        pre_tick   = prescale_on ? (pre_cnt_ff == `SCC_PRESCALE_LAST) : 1'b1;
    wire        gap_start  = frame_end_i & (gap_val_ff != `SCC_GAP_RESET);
    wire        gap_last   = gap_active_ff & pre_tick
                           & (gap_left_ff == `SCC_GAP_W'(1));
    assign nxt_gap_active = gap_start | (gap_active_ff & ~gap_last);
    assign nxt_gap_left   = gap_start ? gap_val_ff
                          : (gap_active_ff & pre_tick) ? gap_left_ff - `SCC_GAP_W'(1)
                          : gap_left_ff;
    assign nxt_pre_cnt    = (gap_start || !gap_active_ff) ? 5'h00
                          : pre_cnt_ff + 5'h01;

    // ============================================================
    // Read mux
    // Unmapped words and reserved bits read as zero
    // Byte lanes are ignored on reads; the whole word is returned
    wire [31:0] rd_master = {24'h000000, mode_ff, 6'h00};
    wire [31:0] rd_gap    = {22'h000000, gap_val_ff};
    wire [31:0] rd_status = {28'h0000000, irq_status_ff};
    wire [31:0] rd_mask   = {28'h0000000, irq_mask_ff};
    wire [31:0] rd_mux    = hit_master ? rd_master
                          : hit_ctrl0  ? ctrl_zero_ff
                          : hit_gap    ? rd_gap
                          : hit_status ? rd_status
                          : hit_mask   ? rd_mask
                          : 32'h00000000;

    // Sampling edge: polarity xor phase tells which edge samples
    wire        nxt_sample_rise = ~(nxt_ctrl_zero[`SCC_POLARITY_BIT]
                                  ^ nxt_ctrl_zero[`SCC_PHASE_BIT]);

    // ============================================================
    // Bus handshake: one wait cycle, ack drops in the cycle after it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff   <= 1'b0;
        end
        else if (ce_i)
        begin
            ack_ff   <= bus_req & ~ack_ff;
        end
    end

    // Read data follows the address every cycle; the master takes it with ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= 32'h00000000;
        end
        else if (ce_i)
        begin
            rdata_ff <= rd_mux;
        end
    end

    // Control register and mode field
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_zero_ff  <= `SCC_CTRL_ZERO_RESET;
            mode_ff       <= `SCC_MODE_RESET;
        end
        else if (ce_i)
        begin
            ctrl_zero_ff  <= nxt_ctrl_zero;
            mode_ff       <= nxt_mode;
        end
    end

    // Registered mode flags, so the outputs come straight from flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            config_ff     <= 1'b0;
            active_ff     <= 1'b0;
        end
        else if (ce_i)
        begin
            config_ff     <= nxt_config;
            active_ff     <= nxt_active;
        end
    end

    // Gap value, interrupt mask and sticky status
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gap_val_ff    <= `SCC_GAP_RESET;
            irq_mask_ff   <= `SCC_IRQ_RESET;
            irq_status_ff <= `SCC_IRQ_RESET;
        end
        else if (ce_i)
        begin
            gap_val_ff    <= nxt_gap_val;
            irq_mask_ff   <= nxt_irq_mask;
            irq_status_ff <= nxt_irq_status;
        end
    end

    // Gap timer state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gap_active_ff <= 1'b0;
            gap_left_ff   <= `SCC_GAP_RESET;
            pre_cnt_ff    <= 5'h00;
        end
        else if (ce_i)
        begin
            gap_active_ff <= nxt_gap_active;
            gap_left_ff   <= nxt_gap_left;
            pre_cnt_ff    <= nxt_pre_cnt;
        end
    end

    // Registered fill flags, one cycle behind the live counts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_fill_ff     <= 1'b0;
            rx_fill_ff     <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_fill_ff     <= tx_fill_now;
            rx_fill_ff     <= rx_fill_now;
        end
    end

    // Interrupt line and sampling edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_ff         <= 1'b0;
            sample_rise_ff <= 1'b1;
        end
        else if (ce_i)
        begin
            irq_ff         <= nxt_irq;
            sample_rise_ff <= nxt_sample_rise;
        end
    end

    // ============================================================
    // Outputs, all straight from flops
    // Mode flags are registered copies, not decoded after the flop
    // Polarity is meant to change only with chip select released; the
    // block cannot see chip select, so it does not guard this itself
    assign wb_ack_o           = ack_ff;
    assign wb_dat_o           = rdata_ff;
    assign operation_mode_o   = mode_ff;
    assign config_mode_o      = config_ff;
    assign active_mode_o      = active_ff;
    assign bit_order_select_o = ctrl_zero_ff[`SCC_ORDER_BIT];
    assign clock_phase_o      = ctrl_zero_ff[`SCC_PHASE_BIT];
    assign clock_polarity_o   = ctrl_zero_ff[`SCC_POLARITY_BIT];
    assign sample_on_rise_o   = sample_rise_ff;
    assign gap_active_o       = gap_active_ff;
    assign tx_fill_flag_o     = tx_fill_ff;
    assign rx_fill_flag_o     = rx_fill_ff;
    assign irq_o              = irq_ff;

endmodule // scc_ctrl

// *** tb/scc_ctrl_chk.sv ***
// Port-level assertions for the SPI control block
`include "scc_defs.svh"
`timescale 1ns/1ps
module scc_ctrl_chk
    import scc_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [`SCC_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    input  wire logic                   wb_ack_o,
    input  wire logic [2:0]             tx_free_count_i,
    input  wire logic [2:0]             rx_held_count_i,
    input  wire logic                   frame_end_i,
    input  wire logic [1:0]             operation_mode_o,
    input  wire logic                   config_mode_o,
    input  wire logic                   active_mode_o,
    input  wire logic                   bit_order_select_o,
    input  wire logic                   clock_phase_o,
    input  wire logic                   clock_polarity_o,
    input  wire logic                   sample_on_rise_o,
    input  wire logic                   gap_active_o,
    input  wire logic                   tx_fill_flag_o,
    input  wire logic                   rx_fill_flag_o,
    input  wire logic                   irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ============================================================
    // Bus steps; a protected write only counts when it lands in config mode
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    wire cfg_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && ce_i && wb_sel_i[0]
                  && wb_adr_i[15:2] == 14'h3E01 && config_mode_o;
    // ============================================================
    // Assertions
    reset_values_a: assert property (disable iff (1'b0) rst_i && ce_i |=> !irq_o && !wb_ack_o
        && sample_on_rise_o && operation_mode_o == 2'h0 && !gap_active_o && !clock_polarity_o)
        else $error("state not cleared by reset");
    ack_after_req_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single pulse one cycle after request");
    ack_only_req_a: assert property (!wb_stb_i && !wb_ack_o |=> !wb_ack_o)
        else $error("bus answer without request");
    prot_hold_a: assert property (!cfg_wr |=> $stable({bit_order_select_o, clock_phase_o,
        clock_polarity_o})) else $error("protected bit moved without config write");
    prot_load_a: assert property (cfg_wr |=> {bit_order_select_o, clock_phase_o,
        clock_polarity_o} == $past(wb_dat_i[2:0])) else $error("config write not taken");
    sample_edge_a: assert property (sample_on_rise_o == !(clock_polarity_o ^ clock_phase_o))
        else $error("sample edge disagrees with phase and polarity");
    mode_decode_a: assert property (config_mode_o == (operation_mode_o == 2'b01)
        && active_mode_o == (operation_mode_o == 2'b10)) else $error("mode decode wrong");
    tx_fill_full_a: assert property (ce_i && tx_free_count_i == 3'h4 |=> tx_fill_flag_o)
        else $error("transmit fill missing with all entries free");
    rx_fill_empty_a: assert property (ce_i && rx_held_count_i == 3'h0 |=> !rx_fill_flag_o)
        else $error("receive fill raised with empty buffer");
    gap_cause_a: assert property ($rose(gap_active_o) |-> $past(frame_end_i))
        else $error("gap started without frame end");
endmodule // scc_ctrl_chk

bind scc_ctrl scc_ctrl_chk i_scc_ctrl_chk (.*);

// *** tb/scc_spi_peer.sv ***
// Far-side stand-in: buffer levels, idle, overrun and frame-end from the shift engine
`timescale 1ns/1ps
module scc_spi_peer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cs_n_i,
    input  wire logic       polarity_i,
    input  wire logic [2:0] tx_req_i,
    input  wire logic [2:0] rx_req_i,
    input  wire logic       idle_req_i,
    input  wire logic       ovr_req_i,
    input  wire logic       end_req_i,
    output logic      [2:0] tx_free_count_o,
    output logic      [2:0] rx_held_count_o,
    output logic            idle_flag_o,
    output logic            overrun_flag_o,
    output logic            frame_end_o,
    output logic            select_err_o
);
    logic pol_seen;
    // ============================================================
    // One register stage, as the engine would present its levels
    always_ff @(posedge clk_i)
    begin
        tx_free_count_o <= rst_i ? 3'h0 : tx_req_i;
        rx_held_count_o <= rst_i ? 3'h0 : rx_req_i;
        idle_flag_o     <= !rst_i && idle_req_i;
        overrun_flag_o  <= !rst_i && ovr_req_i;
        frame_end_o     <= !rst_i && end_req_i;
        pol_seen        <= polarity_i;
        // A selected slave would see a false clock edge
        select_err_o    <= !rst_i && (select_err_o || (!cs_n_i && pol_seen != polarity_i));
    end
endmodule // scc_spi_peer

// *** tb/scc_ctrl_tb_top.sv ***
// Self-checking bench for the SPI control block
`timescale 1ns/1ps
module scc_ctrl_tb_top;
    import scc_pkg::*;
    logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cs_n, select_err;
    logic [15:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q, r;
    logic        idle_flag_i, overrun_flag_i, frame_end_i, idle_req, ovr_req, end_req;
    logic [2:0]  tx_free_count_i, rx_held_count_i, tx_req, rx_req;
    logic [1:0]  operation_mode_o;
    logic        config_mode_o, active_mode_o, bit_order_select_o, clock_phase_o, irq_o;
    logic        clock_polarity_o, sample_on_rise_o, gap_active_o, tx_fill_flag_o, rx_fill_flag_o;
    int          n_mismatch, total_checks, ctrl_m, mode_m, cnt;
    int          gv[3] = '{3, 2, 0};
    int          ps[3] = '{0, 1, 0};
    logic [15:0] ofs[6] = '{16'hF800, 16'hF804, 16'hF80C, 16'hF814, 16'hF820, 16'hF810};

    scc_ctrl i_scc_ctrl (.*);
    scc_spi_peer i_scc_spi_peer (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n),
        .polarity_i(clock_polarity_o), .tx_req_i(tx_req), .rx_req_i(rx_req),
        .idle_req_i(idle_req), .ovr_req_i(ovr_req), .end_req_i(end_req),
        .tx_free_count_o(tx_free_count_i), .rx_held_count_o(rx_held_count_i),
        .idle_flag_o(idle_flag_i), .overrun_flag_o(overrun_flag_i),
        .frame_end_o(frame_end_i), .select_err_o(select_err));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ============================================================
    // Shared tasks
    task automatic complete_run();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Classic single cycle; read data taken only at the ack edge
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_mismatch++;
            complete_run();
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic raise(input int s, input bit v);
        idle_req <= v && s == 0;
        ovr_req  <= v && s == 1;
        rx_req   <= (v && s == 2) ? 3'h4 : 3'h0;
        tx_req   <= (v && s == 3) ? 3'h4 : 3'h0;
    endtask
    // ============================================================
    // Main sequence
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, idle_req, ovr_req, end_req} = '0;
        {tx_req, rx_req, n_mismatch, total_checks, ctrl_m} = '0;
        {rst_i, ce_i, cs_n, wb_sel_i} = {3'b111, 4'hF};
        void'($urandom(9815));
        tick(3);
        rst_i <= 1'b0;
        // Reset contents, then a write into the hole that must vanish
        check({sample_on_rise_o, irq_o, gap_active_o, clock_polarity_o}, 4'h8);
        bus(1'b1, 16'hF810, 32'hFFFFFFFF);
        foreach (ofs[i])
        begin
            bus(1'b0, ofs[i], 32'h0);
            check(q, 32'h0);
        end
        // Every mode, random data; slave stays deselected while polarity moves
        for (int i = 0; i < 12; i++)
        begin
            mode_m = i % 4;
            r = $urandom;
            bus(1'b1, 16'hF800, 32'(mode_m) << 6);
            bus(1'b1, 16'hF804, r);
            ctrl_m = (mode_m == 1) ? (r & 32'hFF17) : ((ctrl_m & 32'h17) | (r & 32'hFF00));
            bus(1'b0, 16'hF804, 32'h0);
            check(q, ctrl_m);
            check({config_mode_o, active_mode_o, operation_mode_o,
                bit_order_select_o, clock_phase_o, clock_polarity_o,
                sample_on_rise_o}, {mode_m == 1, mode_m == 2, 2'(mode_m),
                3'(ctrl_m), ctrl_m[0] == ctrl_m[1]});
        end
        bus(1'b1, 16'hF800, 32'h40);
        // Every threshold code against every fill level
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 5; n++)
            begin
                bus(1'b1, 16'hF804, (c << 14) | (c << 12));
                tx_req <= 3'(n);
                rx_req <= 3'(4 - n);
                tick(3);
                check({tx_fill_flag_o, rx_fill_flag_o}, {n > c, 4 - n > c});
            end
        raise(0, 1'b0);
        cs_n <= 1'b0;
        bus(1'b1, 16'hF814, 32'hF);
        bus(1'b1, 16'hF820, 32'hF);
        // Each source: disabled yet latched, enabled, masked, cleared
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, 16'hF804, 32'hF00 ^ (32'h1 << (11 - s)));
            raise(s, 1'b1);
            tick(4);
            check(irq_o, 1'b0);
            bus(1'b0, 16'hF814, 32'h0);
            check(q, 32'h1 << s);
            bus(1'b1, 16'hF804, 32'h1 << (11 - s));
            tick(2);
            check(irq_o, 1'b1);
            bus(1'b1, 16'hF820, 32'h0);
            tick(2);
            check(irq_o, 1'b0);
            raise(s, 1'b0);
            bus(1'b1, 16'hF820, 32'hF);
            bus(1'b1, 16'hF814, 32'hF);
            tick(2);
            check(irq_o, 1'b0);
        end
        // Gap lengths, with and without prescale, and a zero gap
        foreach (gv[k])
        begin
            bus(1'b1, 16'hF804, ps[k] << 4);
            bus(1'b1, 16'hF80C, gv[k]);
            end_req <= 1'b1;
            tick(1);
            end_req <= 1'b0;
            cnt = 0;
            repeat (90) @(posedge clk_i) cnt += (gap_active_o === 1'b1);
            check(cnt, gv[k] * (ps[k] ? 32 : 1));
        end
        check(select_err, 1'b0);
        complete_run();
    end
endmodule // scc_ctrl_tb_top
